//--- logic/cb_pkg.sv
package cb_pkg;

    localparam int          CLK_HZ        = 50_000_000;
    localparam int          SLOW_OSC_HZ   = 32_768;
    // half period of the slow clock, rounded down to whole cycles
    localparam int          SLOW_HALF     = CLK_HZ / (2 * SLOW_OSC_HZ);
    localparam int          SLOW_CNT_W    = 10;
    localparam logic [9:0]  SLOW_LAST     = 10'(SLOW_HALF - 1);

    // four-step phase divider: a high in step 0, b high in step 2
    localparam logic [1:0]  PHASE_A_STEP  = 2'h0;
    localparam logic [1:0]  PHASE_B_STEP  = 2'h2;

    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 4;
    localparam int          WORD_ADDR_W   = 6;
    localparam int          IRQ_N         = 4;
    localparam int          CUSTOM_WORDS  = 64;

    localparam logic [15:0] CUSTOM_FIRST  = 16'hFF80;
    localparam logic [15:0] CUSTOM_LAST   = 16'hFFBF;
    localparam logic [15:0] TUNE_CTRL_ADR = 16'hFF68;
    localparam int          TUNE_BIT_POS  = 0;
    localparam logic [15:0] IRQ_EN_ADR    = 16'hFFE0;
    localparam logic [15:0] IRQ_PEND_ADR  = 16'hFFF0;

    localparam logic [3:0]  IRQ_EN_RESET  = 4'h0;
    localparam logic [3:0]  IRQ_PEND_RST  = 4'h0;
    localparam logic [3:0]  CUSTOM_RESET  = 4'h0;
    localparam logic [3:0]  READ_ZERO     = 4'h0;

    // shared vector of the custom block and the tune generator
    localparam logic [15:0] SHARED_VECTOR = 16'h0102;

endpackage : cb_pkg

//--- logic/cb_if.sv
`timescale 1ns/1ns
interface cb_if;
    import cb_pkg::*;

    logic                   slow_osc_clock_out;
    logic                   phase_clock_a;
    logic                   phase_clock_b;
    logic [DATA_W-1:0]      write_data_bus;
    logic [DATA_W-1:0]      read_data_bus;
    logic [WORD_ADDR_W-1:0] word_address_bus;
    logic                   custom_io_select_n;
    logic                   custom_write_strobe_n;
    logic                   custom_read_strobe_n;
    logic                   custom_reset_n;
    logic [IRQ_N-1:0]       custom_irq_request_n;
    logic                   tune_signal_to_custom;
    logic                   tune_play_control_from_custom;

    modport core_end (
        output slow_osc_clock_out,
        output phase_clock_a,
        output phase_clock_b,
        output write_data_bus,
        input  read_data_bus,
        output word_address_bus,
        output custom_io_select_n,
        output custom_write_strobe_n,
        output custom_read_strobe_n,
        output custom_reset_n,
        input  custom_irq_request_n,
        output tune_signal_to_custom,
        input  tune_play_control_from_custom
    );

    modport custom_end (
        input  slow_osc_clock_out,
        input  phase_clock_a,
        input  phase_clock_b,
        input  write_data_bus,
        output read_data_bus,
        input  word_address_bus,
        input  custom_io_select_n,
        input  custom_write_strobe_n,
        input  custom_read_strobe_n,
        input  custom_reset_n,
        output custom_irq_request_n,
        input  tune_signal_to_custom,
        output tune_play_control_from_custom
    );

endinterface : cb_if

//--- logic/core_end.sv
// How it works
// RULE1: six-bit word address reaches 64 custom words
// RULE2: select only for addresses FF80 to FFBF
// RULE3: writes go out on own write bus
// RULE4: custom block answers reads on read bus
// RULE5: write strobe on every custom-range write
// RULE6: read strobe on every custom-range read
// RULE7: slow oscillator clock forwarded as own output; here a divided copy of clk with a 762-cycle half period
// RULE8: two non-overlapping phase clocks from divider
// RULE9: custom control acts like tune start bit
// RULE10: tune generator output forwarded to custom block
// RULE11: four independent request lines, zero to three
// RULE12: falling edge sets pending, raises interrupt
// RULE13: mask blocks request, flag still sets
// RULE14: write one clears, zero keeps, read shows
// RULE15: enable register, bit n enables line n
// RULE16: pending register, bit n is line n
// RULE17: all share the tune interrupt vector
// RULE18: reset clears enables and pending flags
// RULE19: enabled flag left set raises again
// RULE20: accepting interrupt clears global enable
// RULE21: custom reset asserted during core reset
// RULE22: lines sampled, edge from consecutive samples
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module core_end
    import cb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              tune_gen_out,
    output logic                   tune_play,
    input  wire logic              int_enable,
    input  wire logic              int_accept,
    output logic                   int_global_enable,
    output logic                   int_request,
    output logic      [ADDR_W-1:0] int_vector,
    cb_if.core_end                 link
);
    import cb_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]     rdata;
        logic [IRQ_N-1:0]      enable;
        logic [IRQ_N-1:0]      pending;
        logic [IRQ_N-1:0]      irq_now;
        logic [IRQ_N-1:0]      irq_prev;
        logic                  gie;
        logic                  irq;
        logic                  tune_bit;
        logic                  tune_play;
        logic                  tune_sig;
        logic [SLOW_CNT_W-1:0] slow_cnt;
        logic                  slow_clk;
        logic [1:0]            phase_cnt;
        logic                  ph_a;
        logic                  ph_b;
        logic                  rst_n;
        logic [ADDR_W-1:0]     vector;
    } core_state_t;

    core_state_t state_reg;
    core_state_t state_next;

    logic              sel_custom;
    logic [IRQ_N-1:0]  fall;
    logic [IRQ_N-1:0]  clr;
    logic [IRQ_N-1:0]  pend_new;
    logic [IRQ_N-1:0]  armed;

    function automatic logic in_custom(input logic [ADDR_W-1:0] a);
        in_custom = (a >= CUSTOM_FIRST) && (a <= CUSTOM_LAST);
    endfunction : in_custom

    // one decoder for every write to a core register; the read mux below
    // compares the address against each register directly instead
    function automatic logic hit(input logic              strobe,
                                 input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] target);
        hit = strobe && (a == target);
    endfunction : hit

    // the bus pins follow the software port in the same cycle so the
    // custom read answer can be caught at the next edge; a registered
    // select would cost the port its one-cycle read latency
    assign sel_custom = in_custom(addr) && (wr || rd);           // [RULE2]
    assign link.custom_io_select_n    = ~sel_custom;             // [RULE2]
    assign link.custom_write_strobe_n = ~(sel_custom && wr);     // [RULE5]
    assign link.custom_read_strobe_n  = ~(sel_custom && rd);     // [RULE6]
    assign link.word_address_bus      = addr[WORD_ADDR_W-1:0];   // [RULE1]
    assign link.write_data_bus        = wdata;                   // [RULE3]

    assign link.slow_osc_clock_out    = state_reg.slow_clk;
    assign link.phase_clock_a         = state_reg.ph_a;
    assign link.phase_clock_b         = state_reg.ph_b;
    assign link.custom_reset_n        = state_reg.rst_n;
    assign link.tune_signal_to_custom = state_reg.tune_sig;

    assign rdata             = state_reg.rdata;
    assign tune_play         = state_reg.tune_play;
    assign int_global_enable = state_reg.gie;
    assign int_request       = state_reg.irq;
    assign int_vector        = state_reg.vector;

    assign clr   = hit(wr, addr, IRQ_PEND_ADR) ? wdata : '0;     // [RULE14]
    // a masked line is never armed, yet its flag still records edges
    assign armed = state_reg.pending & state_reg.enable;         // [RULE13]

    // one detector per line: the four lines never affect each other
    for (genvar i = 0; i < IRQ_N; i++) begin : g_line
        assign fall[i] = state_reg.irq_prev[i] &
                         ~state_reg.irq_now[i];                  // [RULE22]
        // an edge in the same cycle as its clear keeps the flag set
        assign pend_new[i] = (state_reg.pending[i] & ~clr[i]) |
                             fall[i];                            // [RULE12]
    end

    always_comb begin
        state_next = state_reg;

        // two samples give the edge; inputs arrive synchronous to clk
        state_next.irq_now  = link.custom_irq_request_n;         // [RULE22]
        state_next.irq_prev = state_reg.irq_now;                 // [RULE11]

        // flags set regardless of the mask
        state_next.pending = pend_new;                           // [RULE13]

        if (hit(wr, addr, IRQ_EN_ADR)) begin
            state_next.enable = wdata;                           // [RULE15]
        end
        // only the start bit is kept; the rest of that word is not ours
        if (hit(wr, addr, TUNE_CTRL_ADR)) begin
            state_next.tune_bit = wdata[TUNE_BIT_POS];
        end

        // accept wins over a same-cycle enable: the handler runs with
        // interrupts off until it re-enables them itself
        if (int_accept) begin
            state_next.gie = 1'b0;                               // [RULE20]
        end else if (int_enable) begin
            state_next.gie = 1'b1;
        end

        // level request: a flag left set re-raises on re-enable, so the
        // handler must clear its flag before it turns interrupts back on
        state_next.irq = state_reg.gie && !int_accept && |armed; // [RULE19]
        // one vector for every source: only the flags tell them apart
        state_next.vector = SHARED_VECTOR;                       // [RULE17]

        // custom control ored with the software start bit
        // either side may start the tune; neither can stop the other's
        state_next.tune_play = state_reg.tune_bit |
                               link.tune_play_control_from_custom; // [RULE9]
        state_next.tune_sig  = tune_gen_out;                     // [RULE10]

        // rdata stands for one cycle; an unmapped read answers zero
        state_next.rdata = READ_ZERO;
        if (rd) begin
            if (in_custom(addr)) begin
                state_next.rdata = link.read_data_bus;           // [RULE4]
            end else if (addr == IRQ_EN_ADR) begin
                state_next.rdata = state_reg.enable;             // [RULE15]
            end else if (addr == IRQ_PEND_ADR) begin
                state_next.rdata = state_reg.pending;            // [RULE16]
            end else if (addr == TUNE_CTRL_ADR) begin
                state_next.rdata = {3'h0, state_reg.tune_bit};
            end
        end

        // slow clock as a divided square wave on the single clock
        // the half period is rounded down, so the copy runs a little
        // fast; it serves as a timing reference, not as a crystal
        if (state_reg.slow_cnt == SLOW_LAST) begin
            state_next.slow_cnt = '0;
            state_next.slow_clk = ~state_reg.slow_clk;           // [RULE7]
        end else begin
            state_next.slow_cnt = state_reg.slow_cnt + 1'b1;
        end

        // a gap step after each phase keeps them from overlapping
        // both phases come from one counter, so their spacing cannot drift
        state_next.phase_cnt = state_reg.phase_cnt + 1'b1;
        state_next.ph_a = (state_next.phase_cnt == PHASE_A_STEP); // [RULE8]
        state_next.ph_b = (state_next.phase_cnt == PHASE_B_STEP); // [RULE8]

        // the custom end leaves reset one edge after the core
        state_next.rst_n = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg           <= '0;
            state_reg.enable    <= IRQ_EN_RESET;                 // [RULE18]
            state_reg.pending   <= IRQ_PEND_RST;                 // [RULE18]
            // samples start at the idle level, so leaving reset is no edge
            state_reg.irq_now   <= '1;
            state_reg.irq_prev  <= '1;
            state_reg.rst_n     <= 1'b0;                         // [RULE21]
            // the vector shows its constant even while held in reset
            state_reg.vector    <= SHARED_VECTOR;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : core_end

//--- logic/custom_end.sv
`timescale 1ns/1ns
module custom_end
    import cb_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic [IRQ_N-1:0]       irq_raise,
    input  wire logic                   tune_play_req,
    input  wire logic [WORD_ADDR_W-1:0] peek_addr,
    output logic      [DATA_W-1:0]      peek_data,
    output logic                        word_written,
    output logic      [WORD_ADDR_W-1:0] written_addr,
    output logic                        tune_signal,
    output logic                        in_reset,
    cb_if.custom_end                    link
);
    import cb_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]      peek;
        logic                   wr_pulse;
        logic [WORD_ADDR_W-1:0] wr_addr;
        logic [IRQ_N-1:0]       irq_n;
        logic                   tune_ctl;
        logic                   tune_sig;
        logic                   rst;
    } custom_state_t;

    custom_state_t state_reg;
    custom_state_t state_next;

    logic [DATA_W-1:0] words [CUSTOM_WORDS];
    logic              do_write;
    logic              hold_reset;

    assign hold_reset = srst || !link.custom_reset_n;            // [RULE21]
    assign do_write   = !link.custom_io_select_n &&
                        !link.custom_write_strobe_n;

    // read answer is combinational so the core catches it in the strobe
    assign link.read_data_bus = (!link.custom_io_select_n &&
                                 !link.custom_read_strobe_n) ?
                                words[link.word_address_bus] :
                                READ_ZERO;                        // [RULE4]
    assign link.custom_irq_request_n          = state_reg.irq_n; // [RULE11]
    assign link.tune_play_control_from_custom = state_reg.tune_ctl; // [RULE9]

    assign peek_data    = state_reg.peek;
    assign word_written = state_reg.wr_pulse;
    assign written_addr = state_reg.wr_addr;
    assign tune_signal  = state_reg.tune_sig;
    assign in_reset     = state_reg.rst;

    always_comb begin
        state_next          = state_reg;
        state_next.peek     = words[peek_addr];
        state_next.wr_pulse = do_write;
        if (do_write) begin
            state_next.wr_addr = link.word_address_bus;          // [RULE1]
        end
        // active-low lines: a raise gives the falling edge the core sees
        state_next.irq_n    = ~irq_raise;                        // [RULE11]
        state_next.tune_ctl = tune_play_req;                     // [RULE9]
        state_next.tune_sig = link.tune_signal_to_custom;
        state_next.rst      = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (hold_reset) begin
            state_reg       <= '0;
            state_reg.irq_n <= '1;
            state_reg.rst   <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    generate
        for (genvar i = 0; i < CUSTOM_WORDS; i++) begin : g_word
            always_ff @(posedge clk) begin
                if (hold_reset) begin
                    words[i] <= CUSTOM_RESET;
                end else if (do_write &&
                             link.word_address_bus == WORD_ADDR_W'(i)) begin
                    words[i] <= link.write_data_bus;             // [RULE3]
                end
            end
        end
    endgenerate

endmodule : custom_end

//--- sim/cb_properties.sv
`timescale 1ns/1ns
module cb_properties (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire logic                     slow_osc_clock_out,
    input wire logic                     phase_clock_a,
    input wire logic                     phase_clock_b,
    input wire logic [cb_pkg::DATA_W-1:0] read_data_bus,
    input wire logic                     custom_io_select_n,
    input wire logic                     custom_write_strobe_n,
    input wire logic                     custom_read_strobe_n,
    input wire logic                     custom_reset_n,
    input wire logic [cb_pkg::IRQ_N-1:0] custom_irq_request_n
);
    import cb_pkg::*;
    default clocking cb @(posedge clk); endclocking
    sequence phase_gap;
        !phase_clock_a [*3];
    endsequence
    sequence osc_hold;
        $stable(slow_osc_clock_out) [*8];
    endsequence
    a_write_selects: assert property (disable iff (srst)
        !custom_write_strobe_n |-> !custom_io_select_n && custom_read_strobe_n)
        else $error("write strobe outside select");
    a_read_selects: assert property (disable iff (srst)
        !custom_read_strobe_n |-> !custom_io_select_n && custom_write_strobe_n)
        else $error("read strobe outside select");
    a_select_strobed: assert property (disable iff (srst)
        !custom_io_select_n |-> custom_write_strobe_n != custom_read_strobe_n)
        else $error("select without exactly one strobe");
    a_phase_apart: assert property (disable iff (srst)
        !(phase_clock_a && phase_clock_b))
        else $error("phase clocks overlap");
    a_phase_period: assert property (disable iff (srst)
        phase_clock_a |=> phase_gap ##1 phase_clock_a)
        else $error("phase a period not four cycles");
    a_phase_order: assert property (disable iff (srst)
        phase_clock_a |-> ##2 phase_clock_b)
        else $error("phase b not two cycles after a");
    a_osc_steady: assert property (disable iff (srst)
        $changed(slow_osc_clock_out) |=> osc_hold)
        else $error("slow clock toggles too fast");
    a_reset_out: assert property (srst |=> !custom_reset_n)
        else $error("custom reset not driven in reset");
    a_reset_leave: assert property (disable iff (srst)
        $fell(srst) |=> custom_reset_n)
        else $error("custom reset not released");
    a_read_idle: assert property (disable iff (srst)
        custom_read_strobe_n |-> read_data_bus == 4'h0)
        else $error("read bus driven without read");
    a_irq_idle: assert property (
        !custom_reset_n |=> &custom_irq_request_n)
        else $error("request lines active in reset");
endmodule : cb_properties

//--- sim/custom_block_bus_interface_tb.sv
`timescale 1ns/1ns
module custom_block_bus_interface_tb;
    import cb_pkg::*;
    logic clk, srst, wr, rd, tune_gen_out, tune_play, int_enable, int_accept;
    logic gie, int_request, tune_play_req, word_written, tune_signal, ww;
    logic in_reset;
    logic [ADDR_W-1:0]      addr, int_vector;
    logic [DATA_W-1:0]      wdata, rdata, peek_data, got;
    logic [IRQ_N-1:0]       irq_raise;
    logic [WORD_ADDR_W-1:0] peek_addr, written_addr;
    int                     bad_count, n_tests, cycles;
    cb_if link_bus ();
    core_end core_end_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .tune_gen_out(tune_gen_out),
        .tune_play(tune_play), .int_enable(int_enable),
        .int_accept(int_accept), .int_global_enable(gie),
        .int_request(int_request), .int_vector(int_vector), .link(link_bus));
    custom_end custom_end_i (.clk(clk), .srst(srst), .irq_raise(irq_raise),
        .tune_play_req(tune_play_req), .peek_addr(peek_addr),
        .peek_data(peek_data), .word_written(word_written),
        .written_addr(written_addr), .tune_signal(tune_signal),
        .in_reset(in_reset), .link(link_bus));
    cb_properties cb_properties_i (.clk(clk), .srst(srst),
        .slow_osc_clock_out(link_bus.slow_osc_clock_out),
        .phase_clock_a(link_bus.phase_clock_a),
        .phase_clock_b(link_bus.phase_clock_b),
        .read_data_bus(link_bus.read_data_bus),
        .custom_io_select_n(link_bus.custom_io_select_n),
        .custom_write_strobe_n(link_bus.custom_write_strobe_n),
        .custom_read_strobe_n(link_bus.custom_read_strobe_n),
        .custom_reset_n(link_bus.custom_reset_n),
        .custom_irq_request_n(link_bus.custom_irq_request_n));
    task automatic end_sim;
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        n_tests++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic bus_wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1 ww = word_written;
    endtask : bus_wr
    task automatic bus_rd(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : bus_rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic pulse_gie(input logic acc);
        @(posedge clk);
        int_accept <= acc;
        int_enable <= !acc;
        @(posedge clk);
        int_accept <= 1'b0;
        int_enable <= 1'b0;
        settle(2);
    endtask : pulse_gie
    task automatic test_reset;
        check(4'(in_reset), 4'h0);
        check(4'(gie), 4'h0);
        check(4'(int_vector == SHARED_VECTOR), 4'h1);
        bus_rd(IRQ_EN_ADR);
        check(got, 4'h0);
        bus_rd(IRQ_PEND_ADR);
        check(got, 4'h0);
    endtask : test_reset
    task automatic test_words;
        logic [5:0] offs [4] = '{6'h00, 6'h01, 6'h25, 6'h3F};
        foreach (offs[i]) begin
            bus_wr(CUSTOM_FIRST + 16'(offs[i]), offs[i][3:0] ^ 4'hA);
            check(4'(ww), 4'h1);
            check(written_addr[3:0], offs[i][3:0]);
            check(4'(written_addr[5:4]), 4'(offs[i][5:4]));
            bus_rd(CUSTOM_FIRST + 16'(offs[i]));
            check(got, offs[i][3:0] ^ 4'hA);
            @(posedge clk);
            peek_addr <= offs[i];
            settle(2);
            check(peek_data, offs[i][3:0] ^ 4'hA);
        end
        bus_wr(16'hFFC0, 4'h5);
        check(4'(ww), 4'h0);
        bus_rd(CUSTOM_FIRST);
        check(got, 4'hA);
        bus_wr(16'hFF7F, 4'h6);
        check(4'(ww), 4'h0);
        bus_rd(CUSTOM_LAST);
        check(got, 4'h5);
        bus_rd(16'hFF00);
        check(got, 4'h0);
    endtask : test_words
    task automatic test_irq;
        bus_wr(IRQ_EN_ADR, 4'hF);
        pulse_gie(1'b0);
        for (int n = 0; n < IRQ_N; n++) begin
            @(posedge clk);
            irq_raise[n] <= 1'b1;
            settle(6);
            check(4'(int_request), 4'h1);
            bus_rd(IRQ_PEND_ADR);
            check(got, 4'(1 << n));
            bus_wr(IRQ_PEND_ADR, 4'h0);
            bus_rd(IRQ_PEND_ADR);
            check(got, 4'(1 << n));
            pulse_gie(1'b1);
            check(4'(gie | int_request), 4'h0);
            pulse_gie(1'b0);
            check(4'(int_request), 4'h1);
            @(posedge clk);
            irq_raise[n] <= 1'b0;
            bus_wr(IRQ_PEND_ADR, 4'(1 << n));
            settle(2);
            check(4'(int_request), 4'h0);
            bus_rd(IRQ_PEND_ADR);
            check(got, 4'h0);
        end
    endtask : test_irq
    task automatic test_mask;
        bus_wr(IRQ_EN_ADR, 4'hB);
        bus_rd(IRQ_EN_ADR);
        check(got, 4'hB);
        @(posedge clk);
        irq_raise[2] <= 1'b1;
        settle(6);
        check(4'(int_request), 4'h0);
        bus_rd(IRQ_PEND_ADR);
        check(got, 4'h4);
        @(posedge clk);
        irq_raise[2] <= 1'b0;
        bus_wr(IRQ_PEND_ADR, 4'h4);
    endtask : test_mask
    task automatic test_tune;
        @(posedge clk);
        tune_gen_out  <= 1'b1;
        tune_play_req <= 1'b1;
        settle(4);
        check(4'(tune_signal), 4'h1);
        check(4'(tune_play), 4'h1);
        @(posedge clk);
        tune_gen_out  <= 1'b0;
        tune_play_req <= 1'b0;
        settle(4);
        check(4'(tune_signal | tune_play), 4'h0);
        bus_wr(TUNE_CTRL_ADR, 4'h1);
        settle(2);
        check(4'(tune_play), 4'h1);
        bus_rd(TUNE_CTRL_ADR);
        check(got, 4'h1);
        bus_wr(TUNE_CTRL_ADR, 4'h0);
    endtask : test_tune
    task automatic test_race;
        @(posedge clk);
        irq_raise[1] <= 1'b1;
        @(posedge clk);
        // the clear is taken in the very cycle in which the edge lands
        bus_wr(IRQ_PEND_ADR, 4'h2);
        bus_rd(IRQ_PEND_ADR);
        check(got, 4'h2);
        @(posedge clk);
        irq_raise[1] <= 1'b0;
        bus_wr(IRQ_PEND_ADR, 4'h2);
        bus_rd(IRQ_PEND_ADR);
        check(got, 4'h0);
    endtask : test_race
    task automatic wait_slow(output int gap);
        logic last;
        last = link_bus.slow_osc_clock_out;
        gap  = 0;
        while (link_bus.slow_osc_clock_out === last &&
               gap <= 2 * SLOW_HALF) begin
            settle(1);
            gap++;
        end
    endtask : wait_slow
    task automatic test_slow;
        int gap;
        wait_slow(gap);
        wait_slow(gap);
        check(4'(gap == SLOW_HALF), 4'h1);
    endtask : test_slow
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        {srst, wr, rd, tune_gen_out, int_enable, int_accept} = 6'h20;
        {tune_play_req, addr, wdata, irq_raise, peek_addr} = '0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        settle(3);
        test_reset();
        test_words();
        test_irq();
        test_mask();
        test_tune();
        test_race();
        test_slow();
        @(posedge clk);
        irq_raise[0] <= 1'b1;
        settle(6);
        check(4'(int_request), 4'h1);
        @(posedge clk);
        srst      <= 1'b1;
        irq_raise <= '0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 check(4'(in_reset), 4'h1);
        settle(3);
        test_reset();
        end_sim();
    end
endmodule : custom_block_bus_interface_tb
